// File: bench/ctrl_model.sv
`timescale 1ns/100ps
module ctrl_model #(
  parameter int STEP = 16,
  parameter int DLY = 20
) (
  // Clock, reset and turn-on command.
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_on,
  // Lines to the supervisor.
  output logic o_step_start_pulse_n = 1'b1,
  output logic o_supply_hold_n = 1'b0,
  output logic o_drive_inhibit_n = 1'b0
);
  // The one-second timers are shortened so that a run stays brief.
  int on_cnt = 0;
  int hold_cnt = 0;
  always @(posedge i_clk) begin
    hold_cnt <= i_rst ? 0 : (hold_cnt < DLY ? hold_cnt + 1 : hold_cnt);
    o_supply_hold_n <= !i_rst && hold_cnt >= DLY;
    on_cnt <= (i_rst || !i_on) ? 0 : (on_cnt < DLY ? on_cnt + 1 : on_cnt);
    o_step_start_pulse_n <= !(i_on && on_cnt < STEP);
    o_drive_inhibit_n <= i_on && on_cnt >= DLY;
  end
endmodule : ctrl_model

// File: bench/fault_supervisor_sva.sv
`timescale 1ns/100ps
module fault_supervisor_sva
  import fault_pkg::*;
#(
  parameter int unsigned STRETCH_CYC = 20
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Inputs watched.
  input wire apb_req_t i_apb,
  input wire logic i_backup_supply_reset_n,
  input wire logic i_step_start_pulse_n,
  input wire logic i_drive_inhibit_n,
  input wire logic [6:0] i_fault_det,
  input wire logic i_repeat_overload,
  // Outputs watched.
  input wire apb_rsp_t o_apb,
  input wire logic o_shutdown,
  input wire logic [7:0] o_fault_status,
  input wire logic o_air_fault,
  input wire logic o_clear_n,
  input wire air_ind_t o_air_ind
);
  // Length of the current shutdown run, so the stretch can be judged at its end.
  int unsigned hi_cnt;
  always_ff @(posedge i_clk) begin
    hi_cnt <= (i_rst || !o_shutdown) ? 0 : hi_cnt + 1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_step_held; !i_step_start_pulse_n [*6]; endsequence
  sequence s_backup_held; !i_backup_supply_reset_n [*5]; endsequence
  a_step_blocks: assert property (s_step_held |-> o_clear_n)
    else $error("clear during step start");
  a_clear_empties: assert property (!o_clear_n |=> o_fault_status == 8'h00)
    else $error("latch kept during clear");
  a_backup_clears: assert property (s_backup_held |-> o_fault_status == 8'h00)
    else $error("latch kept in backup reset");
  a_repeat_shuts: assert property (i_repeat_overload [*6] |-> o_shutdown)
    else $error("overload without shutdown");
  a_fault_shuts: assert property ((|i_fault_det && i_backup_supply_reset_n) [*6] |-> o_shutdown)
    else $error("fault without shutdown");
  a_stretch_len: assert property ($fell(o_shutdown) |-> hi_cnt >= STRETCH_CYC - 1)
    else $error("shutdown too short");
  a_air_blank: assert property (!i_drive_inhibit_n [*6] |-> o_air_ind == 2'b00)
    else $error("air lamp lit while off");
  a_air_wait: assert property ($rose(i_drive_inhibit_n) |-> (o_air_ind == 2'b00) [*8])
    else $error("air lamp lit too soon");
  a_air_red: assert property (o_air_fault && $stable(o_air_fault) && o_air_ind != 2'b00
    |-> o_air_ind == 2'b10)
    else $error("air fault not red");
  a_retrig_wait: assert property ($rose(o_clear_n) |-> (o_fault_status == 8'h00) [*2])
    else $error("relatch too early");
  a_unmapped_err: assert property (i_apb.psel && i_apb.penable && i_apb.paddr > 12'h008
    |-> o_apb.pslverr)
    else $error("no error on unmapped access");
endmodule : fault_supervisor_sva
bind fault_supervisor fault_supervisor_sva #(.STRETCH_CYC(STRETCH_CYC)) i_sva (.*);

// File: bench/fault_supervisor_tb_top.sv
`timescale 1ns/100ps
module fault_supervisor_tb_top;
  import fault_pkg::*;
  logic clk = 0, rst = 1, remote_n = 1, backup_n = 1, panel = 0, on = 0;
  logic rep = 0, air_sw = 0, red_air = 0, step_n, hold_n, drive_n, shut, air_f, clr_n, se;
  logic [6:0] det = '0;
  logic [7:0] stat;
  logic [31:0] rd;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  air_ind_t ind;
  int err_total = 0, total_checks = 0, falls = 0;
  always #12.5 clk = ~clk;
  always @(negedge clr_n) falls++;
  fault_supervisor #(.DEBOUNCE_CYC(4), .STRETCH_CYC(20), .AIR_INHIBIT_CYC(30)) i_dut (
    .i_clk(clk), .i_rst(rst), .i_apb(req), .o_apb(rsp), .i_remote_reset_n(remote_n),
    .i_backup_supply_reset_n(backup_n), .i_panel_reset(panel), .i_step_start_pulse_n(step_n),
    .i_supply_hold_n(hold_n), .i_drive_inhibit_n(drive_n), .i_fault_det(det),
    .i_repeat_overload(rep), .i_air_switch_fault(air_sw), .i_reduced_air(red_air),
    .o_shutdown(shut), .o_fault_status(stat), .o_air_fault(air_f), .o_clear_n(clr_n),
    .o_air_ind(ind));
  ctrl_model #(.STEP(16), .DLY(20)) i_ctrl (.i_clk(clk), .i_rst(rst), .i_on(on),
    .o_step_start_pulse_n(step_n), .o_supply_hold_n(hold_n), .o_drive_inhibit_n(drive_n));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1;
    @(posedge clk);
    req.penable <= 1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    se = rsp.pslverr;
    req.psel <= 0;
    req.penable <= 0;
  endtask : bus
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    tick(3000);
    err_total++;
    wrap_up();
  end
  initial begin
    tick(8);
    rst <= 0;
    bus(0, 12'h000, '0); chk(rd, 32'h0000_0800);
    bus(0, 12'h00C, '0); chk(rd, 32'h0); chk(32'(se), 32'h1);
    tick(20); det[2] <= 1;
    tick(10); chk(32'(stat), 32'h08); chk(32'(shut), 32'h1);
    det[2] <= 0;
    tick(6); chk(32'(shut), 32'h1);
    tick(30); chk(32'(shut), 32'h0); chk(32'(stat), 32'h08);
    rep <= 1;
    tick(40); chk(32'(shut), 32'h1); rep <= 0;
    tick(30); det[4] <= 1;
    // Single-cycle presses must not get past the debounce.
    repeat (3) begin
      tick(1); panel <= 1;
      tick(1); panel <= 0;
    end
    tick(10); panel <= 1;
    tick(10); panel <= 0;
    tick(20); chk(falls, 1); chk(32'(stat), 32'h20);
    det[4] <= 0; remote_n <= 0;
    tick(10); remote_n <= 1;
    tick(20); chk(falls, 2); chk(32'(stat), 32'h0);
    bus(1, 12'h004, 32'h1);
    tick(10); chk(falls, 3);
    on <= 1; air_sw <= 1;
    tick(2); panel <= 1;
    tick(6); panel <= 0;
    tick(12); chk(falls, 3);
    tick(20); chk(32'(air_f), 32'h0); chk(32'(shut), 32'h0); chk(32'(ind), 32'h0);
    air_sw <= 0;
    tick(30); chk(32'(ind), 32'h1); red_air <= 1;
    tick(5); chk(32'(ind), 32'h3); chk(32'(shut), 32'h0);
    red_air <= 0; air_sw <= 1;
    tick(8); chk(32'(air_f), 32'h1); chk(32'(ind), 32'h2); chk(32'(shut), 32'h1);
    backup_n <= 0;
    tick(6); chk(32'(stat), 32'h0);
    backup_n <= 1; air_sw <= 0;
    tick(5);
    wrap_up();
  end
endmodule : fault_supervisor_tb_top

// File: hw/fault_supervisor.sv
`timescale 1ns/100ps
`include "fault_consts.svh"
// Contract
// - Fault with retrigger high clocks its latch.
// - Retrigger rise relatches faults still present.
// - Retrigger rises after reset or supply good.
// - Backup reset clears latches, masks detections.
// - Remote or backup reset requests clear.
// - Panel switch requests the same clear.
// - Reset inputs are debounced to one request.
// - Step-start pulse blocks every clear request.
// - Clear pulse holds all latches healthy.
// - Retrigger is clear delayed 3 clocks, 75 ns.
// - Shutdown output turns the transmitter off.
// - Eight fault detections are ORed together.
// - Repeated overload input joins the OR.
// - Fault rise sets a self-clearing stretcher.
// - Shutdown lasts 2.4 s or fault length.
// - Reduced airflow shows amber, no fault.
// - Airflow fault shows red, feeds shutdown.
// - Airflow fault gated by 20 s inhibit.
// - Air indicator blank 20 s after turn-on.
// - Latched air fault: red, no green, output.
// - Latch sets on rise, clears while clear low.
// - Supply hold keeps retrigger low at power-up.
module fault_supervisor
  import fault_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = `DEBOUNCE_MS * `CLK_KHZ,
  parameter int unsigned STRETCH_CYC = `STRETCH_MS * `CLK_KHZ,
  parameter int unsigned AIR_INHIBIT_CYC = `AIR_INHIBIT_MS * `CLK_KHZ
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // APB slave.
  input wire apb_req_t i_apb,
  output apb_rsp_t o_apb,
  // Reset sources and controller status pins.
  input wire logic i_remote_reset_n,
  input wire logic i_backup_supply_reset_n,
  input wire logic i_panel_reset,
  input wire logic i_step_start_pulse_n,
  input wire logic i_supply_hold_n,
  input wire logic i_drive_inhibit_n,
  // Fault detection pins.
  input wire logic [`NUM_FAULTS-2:0] i_fault_det,
  input wire logic i_repeat_overload,
  input wire logic i_air_switch_fault,
  input wire logic i_reduced_air,
  // Controller and external interface outputs.
  output logic o_shutdown,
  output logic [`NUM_FAULTS-1:0] o_fault_status,
  output logic o_air_fault,
  output logic o_clear_n,
  // Front-panel air indicator.
  output air_ind_t o_air_ind
);
  localparam int unsigned NPIN = `NUM_FAULTS + 8;

  // Pin synchronisers.
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  assign pin_raw = {i_remote_reset_n, i_backup_supply_reset_n, i_panel_reset,
                    i_step_start_pulse_n, i_supply_hold_n, i_drive_inhibit_n,
                    i_repeat_overload, i_air_switch_fault, i_reduced_air, i_fault_det};

  sync_two #(.W(NPIN)) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(pin_raw),
    .o_sync(pin_s)
  );

  wire logic [`NUM_FAULTS-2:0] ext_det = pin_s[`NUM_FAULTS-2:0];
  wire logic reduced_air = pin_s[`NUM_FAULTS-1];
  wire logic air_switch = pin_s[`NUM_FAULTS];
  wire logic repeat_ovl = pin_s[`NUM_FAULTS+1];
  wire logic drive_on = pin_s[`NUM_FAULTS+2];
  wire logic supply_ok = pin_s[`NUM_FAULTS+3];
  wire logic step_idle = pin_s[`NUM_FAULTS+4];
  wire logic panel_req = pin_s[`NUM_FAULTS+5];
  wire logic backup_n = pin_s[`NUM_FAULTS+6];
  wire logic remote_n = pin_s[`NUM_FAULTS+7];

  // Reset request merge and debounce.
  logic soft_reset;
  logic req_db;
  logic bounce_done;
  wire logic req_raw = !remote_n || !backup_n || panel_req;
  wire logic req_differs = req_raw != req_db;

  // The debounced level only follows a raw level that stood still long enough.
  on_delay #(.LEN(DEBOUNCE_CYC)) u_debounce (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in(req_differs),
    .o_out(bounce_done)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_db <= 1'b0;
    end else if (bounce_done && req_differs) begin
      req_db <= req_raw;
    end
  end

  // Clear pulse and delayed retrigger enable.
  wire logic clear_req = (req_db || soft_reset) && step_idle;
  logic clear_n;
  logic clear_rel_dly;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clear_n <= 1'b1;
    end else begin
      clear_n <= !clear_req;
    end
  end

  on_delay #(.LEN(`RETRIG_CYC)) u_retrig (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in(clear_n),
    .o_out(clear_rel_dly)
  );

  // The supply hold keeps latching off until the controller supply settles.
  wire logic retrig = clear_rel_dly && supply_ok;

  // Airflow inhibit, running from the drive inhibit release.
  logic air_ready;

  on_delay #(.LEN(AIR_INHIBIT_CYC)) u_air_inh (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in(drive_on),
    .o_out(air_ready)
  );

  wire logic air_fault_det = air_switch && air_ready;

  // Fault detections, masked while the backup supply resets.
  wire logic [`NUM_FAULTS-1:0] det = backup_n ? {ext_det, air_fault_det} : '0;

  // Retrigger gates and status latches.
  wire logic [`NUM_FAULTS-1:0] set_in = det & {`NUM_FAULTS{retrig}};
  logic [`NUM_FAULTS-1:0] set_prev;
  logic [`NUM_FAULTS-1:0] latch;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_FAULTS; gi++) begin : g_latch
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          set_prev[gi] <= 1'b0;
          latch[gi] <= 1'b0;
        end else begin
          set_prev[gi] <= set_in[gi];
          if (!backup_n || !clear_n) begin
            latch[gi] <= 1'b0;
          end else if (set_in[gi] && !set_prev[gi]) begin
            latch[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Shutdown aggregation and stretcher.
  wire logic combined = (|det) || repeat_ovl;
  logic comb_prev;
  logic stretch;
  logic [31:0] stretch_cnt;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      comb_prev <= 1'b0;
      stretch <= 1'b0;
      stretch_cnt <= 32'h0000_0000;
    end else begin
      comb_prev <= combined;
      if (combined && !comb_prev) begin
        stretch <= 1'b1;
        stretch_cnt <= 32'h0000_0000;
      end else if (stretch && stretch_cnt >= STRETCH_CYC - 1) begin
        stretch <= 1'b0;
      end else if (stretch) begin
        stretch_cnt <= stretch_cnt + 32'h0000_0001;
      end
    end
  end

  // Outputs to the controller, external interface and panel.
  wire logic air_latched = latch[`AIR_FAULT_IDX];
  wire logic next_red = air_ready && (air_latched || reduced_air);
  wire logic next_green = air_ready && !air_latched;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_shutdown <= 1'b0;
      o_fault_status <= '0;
      o_air_fault <= 1'b0;
      o_clear_n <= 1'b1;
      o_air_ind <= '0;
    end else begin
      o_shutdown <= combined || stretch;
      o_fault_status <= latch;
      o_air_fault <= air_latched;
      o_clear_n <= clear_n;
      o_air_ind.red <= next_red;
      o_air_ind.green <= next_green;
    end
  end

  // APB slave, zero wait states.
  wire logic setup = i_apb.psel && !i_apb.penable;
  wire logic access = i_apb.psel && i_apb.penable;
  wire logic hit_status = i_apb.paddr == `REG_STATUS;
  wire logic hit_ctrl = i_apb.paddr == `REG_CTRL;
  wire logic hit_pins = i_apb.paddr == `REG_PINS;
  wire logic mapped = hit_status || hit_ctrl || hit_pins;

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_LATCH_LSB +: `NUM_FAULTS] = latch;
    status_word[`ST_SHUTDOWN] = combined || stretch;
    status_word[`ST_STRETCH] = stretch;
    status_word[`ST_RETRIG] = retrig;
    status_word[`ST_CLEAR_N] = clear_n;
    status_word[`ST_AIR_READY] = air_ready;
    status_word[`ST_REDUCED_AIR] = reduced_air;
  end

  wire logic [31:0] pins_word = {{(32 - NPIN){1'b0}}, pin_s};
  wire logic [31:0] next_rdata = hit_status ? status_word : (hit_pins ? pins_word : 32'h0000_0000);

  // The response struct has one driver, so the read data lives in its own flop.
  logic [31:0] rdata_q;

  // A soft reset lasts one cycle and still obeys the step-start block.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= access && i_apb.pwrite && hit_ctrl && i_apb.pwdata[`CTRL_SOFT_RESET];
      if (setup && !i_apb.pwrite) begin
        rdata_q <= next_rdata;
      end
    end
  end

  assign o_apb = '{pready: 1'b1, pslverr: access && !mapped, prdata: rdata_q};

endmodule : fault_supervisor

// File: hw/on_delay.sv
`timescale 1ns/100ps
module on_delay #(
  parameter int unsigned LEN = 1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Level in, delayed rise out.
  input wire logic i_in,
  output logic o_out
);
  logic [31:0] cnt;

  // A low input drops the output at once, so only the rise is delayed.
  always_ff @(posedge i_clk) begin
    if (i_rst || !i_in) begin
      cnt <= 32'h0000_0000;
      o_out <= 1'b0;
    end else if (cnt >= LEN - 1) begin
      o_out <= 1'b1;
    end else begin
      cnt <= cnt + 32'h0000_0001;
    end
  end
endmodule : on_delay

// File: hw/sync_two.sv
`timescale 1ns/100ps
module sync_two #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Data.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule : sync_two

// File: include/fault_consts.svh
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH

// Clock and timing.
`define CLK_NS 25
`define CLK_KHZ 40000
`define RETRIG_NS 60
`define RETRIG_CYC ((`RETRIG_NS + `CLK_NS - 1) / `CLK_NS)
`define DEBOUNCE_MS 10
`define STRETCH_MS 2400
`define AIR_INHIBIT_MS 20000

// Fault detection inputs.
`define NUM_FAULTS 8
`define AIR_FAULT_IDX 0

// APB register byte addresses.
`define REG_STATUS 12'h000
`define REG_CTRL 12'h004
`define REG_PINS 12'h008

// Status register fields.
`define ST_LATCH_LSB 0
`define ST_SHUTDOWN 8
`define ST_STRETCH 9
`define ST_RETRIG 10
`define ST_CLEAR_N 11
`define ST_AIR_READY 12
`define ST_REDUCED_AIR 13

// Control register fields.
`define CTRL_SOFT_RESET 0

`endif

// File: include/fault_pkg.sv
package fault_pkg;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic red;
    logic green;
  } air_ind_t;

endpackage : fault_pkg
